// File: verilog/ihbls_steer.sv
/*
  Host address decode and byte lane steering of the 8/16-bit host port.
  Assumes host strobes and address are synchronous to CORE_CLK_I, and that the
  core register file answers reads combinationally from the offsets given.
*/
// Summary of operation
// RULE1: No strap pull-ups selects the ISA-like personality.
// RULE2: Clock strap pull-up only selects 186-like personality.
// RULE3: Both strap pull-ups select the 8-bit personality.
// RULE4: Straps sampled at reset, personality then frozen.
// RULE5: ISA read: low lane offset n, high n or n+1.
// RULE6: ISA write stores low lane only.
// RULE7: 186 read returns the whole aligned offset pair.
// RULE8: 186 write: even takes low, odd high lane.
// RULE9: Address 10h is the packet data port, both lanes.
// RULE10: Address 11h maps to nothing.
// RULE11: Read at 1Eh: upper lane carries no register data.
// RULE12: Read 1Fh triggers soft reset; write stores 1Fh.
`include "ihbls_defs.svh"

module ihbls_steer (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic EEPROM_SELECT_STRAP_I,
  input wire logic EEPROM_CLOCK_STRAP_I,
  input wire logic [`IHBLS_ADDR_W-1:0] ADDR_I,
  input wire logic ADDRESS_ENABLE_INPUT_I,
  input wire logic READ_STROBE_LOW_N_I,
  input wire logic WRITE_STROBE_LOW_N_I,
  input wire logic [`IHBLS_WORD_W-1:0] HOST_DATA_LANES_I,
  output logic [`IHBLS_WORD_W-1:0] HOST_DATA_LANES_O,
  output logic [1:0] HOST_DATA_LANES_OE_N_O,
  output logic [`IHBLS_OFS_W-1:0] CSR_RD_OFS_LO_O,
  output logic [`IHBLS_OFS_W-1:0] CSR_RD_OFS_HI_O,
  input wire logic [`IHBLS_LANE_W-1:0] CSR_RD_DATA_LO_I,
  input wire logic [`IHBLS_LANE_W-1:0] CSR_RD_DATA_HI_I,
  output logic CSR_WR_STB_O,
  output logic [`IHBLS_OFS_W-1:0] CSR_WR_OFS_O,
  output logic [`IHBLS_LANE_W-1:0] CSR_WR_DATA_O,
  input wire logic [`IHBLS_WORD_W-1:0] DP_RD_DATA_I,
  output logic DP_RD_STB_O,
  output logic DP_WR_STB_O,
  output logic [`IHBLS_WORD_W-1:0] DP_WR_DATA_O,
  output logic SOFT_RESET_O,
  output ihbls_pkg::ihbls_mode_t BUS_MODE_O
);
  import ihbls_pkg::*;

  // ====================================================
  // Personality from straps
  ihbls_mode_t mode_reg;
  ihbls_mode_t mode_next;
  logic straps_taken_reg;
  wire logic sel_strap = EEPROM_SELECT_STRAP_I;
  wire logic clk_strap = EEPROM_CLOCK_STRAP_I;

  // Select strap alone has no personality; it falls back to ISA-like
  always_comb
  begin
    case ({sel_strap, clk_strap})
      2'b00: mode_next = IHBLS_MODE_ISA; // RULE1
      2'b01: mode_next = IHBLS_MODE_186; // RULE2
      2'b11: mode_next = IHBLS_MODE_8BIT; // RULE3
      default: mode_next = IHBLS_MODE_ISA;
    endcase
  end

  // Straps caught on the first edge after release, never again
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      mode_reg <= IHBLS_MODE_ISA;
      straps_taken_reg <= 1'b0;
    end
    else if (!straps_taken_reg)
    begin
      mode_reg <= mode_next; // RULE4
      straps_taken_reg <= 1'b1; // RULE4
    end
  end

  wire logic is_186 = (mode_reg == IHBLS_MODE_186);

  // ====================================================
  // Address decode
  function automatic logic addr_is(input logic [`IHBLS_ADDR_W-1:0] a,
                                   input logic [`IHBLS_ADDR_W-1:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  // Address enable only gates ISA-like cycles; the other hosts leave it idle
  wire logic selected = !(mode_reg == IHBLS_MODE_ISA && ADDRESS_ENABLE_INPUT_I);
  // Upper window is not served by this block
  wire logic in_window = ADDR_I[`IHBLS_ADDR_WIN_BIT];
  wire logic [`IHBLS_OFS_W-1:0] ofs = ADDR_I[`IHBLS_OFS_W-1:0];
  wire logic hit_dp = addr_is(ADDR_I, `IHBLS_ADDR_DP);
  wire logic hit_hole = addr_is(ADDR_I, `IHBLS_ADDR_HOLE);
  wire logic hit_half = addr_is(ADDR_I, `IHBLS_ADDR_HALF);
  wire logic hit_srst = addr_is(ADDR_I, `IHBLS_ADDR_SRST);
  wire logic hit_csr = selected && !in_window && !hit_dp && !hit_hole;

  // ====================================================
  // Read steering
  assign CSR_RD_OFS_LO_O = is_186 ? {ofs[`IHBLS_OFS_W-1:1], 1'b0} : ofs; // RULE5 RULE7
  assign CSR_RD_OFS_HI_O = {ofs[`IHBLS_OFS_W-1:1], 1'b1}; // RULE5 RULE7

  logic [`IHBLS_WORD_W-1:0] rd_word;
  always_comb
  begin
    if (!selected || in_window || hit_hole)
      rd_word = `IHBLS_WORD_RST; // RULE10
    else if (hit_dp)
      rd_word = DP_RD_DATA_I; // RULE9
    else if (hit_half)
      rd_word = {`IHBLS_BYTE_RST, CSR_RD_DATA_LO_I}; // RULE11
    else if (!is_186 && ofs[0])
      rd_word = {CSR_RD_DATA_LO_I, CSR_RD_DATA_LO_I}; // RULE5
    else
      rd_word = {CSR_RD_DATA_HI_I, CSR_RD_DATA_LO_I}; // RULE5 RULE7
  end

  logic [`IHBLS_WORD_W-1:0] rd_data_reg;
  logic rd_prev_n_reg;
  wire logic rd_active = !READ_STROBE_LOW_N_I && selected;
  wire logic rd_start = rd_active && rd_prev_n_reg;

  // Data follows the address every cycle of the strobe: one cycle behind
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rd_data_reg <= `IHBLS_WORD_RST;
      rd_prev_n_reg <= 1'b1;
    end
    else
    begin
      rd_data_reg <= rd_word;
      rd_prev_n_reg <= !rd_active;
    end
  end

  assign HOST_DATA_LANES_O = rd_data_reg;
  assign HOST_DATA_LANES_OE_N_O = {2{!rd_active}};

  // ====================================================
  // Read side effects
  logic dp_rd_stb_reg;
  logic soft_reset_reg;
  logic rd_dp_reg;

  // Packet port advances when the read ends, so the word stays put meanwhile
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rd_dp_reg <= 1'b0;
      dp_rd_stb_reg <= 1'b0;
      soft_reset_reg <= 1'b0;
    end
    else
    begin
      rd_dp_reg <= rd_active && hit_dp;
      dp_rd_stb_reg <= rd_dp_reg && !(rd_active && hit_dp); // RULE9
      soft_reset_reg <= rd_start && hit_srst; // RULE12
    end
  end

  assign DP_RD_STB_O = dp_rd_stb_reg;
  assign SOFT_RESET_O = soft_reset_reg;

  // ====================================================
  // Write steering
  wire logic wr_active = !WRITE_STROBE_LOW_N_I && selected;
  wire logic wr_high_lane = is_186 && ofs[0];
  wire logic [`IHBLS_LANE_W-1:0] wr_byte = wr_high_lane ?
    HOST_DATA_LANES_I[`IHBLS_WORD_W-1:`IHBLS_LANE_W] : // RULE8
    HOST_DATA_LANES_I[`IHBLS_LANE_W-1:0]; // RULE6 RULE8

  logic wr_seen_reg;
  logic wr_csr_reg;
  logic wr_dp_reg;
  logic [`IHBLS_OFS_W-1:0] wr_ofs_reg;
  logic [`IHBLS_LANE_W-1:0] wr_byte_reg;
  logic [`IHBLS_WORD_W-1:0] wr_word_reg;
  logic csr_wr_stb_reg;
  logic dp_wr_stb_reg;

  // Last cycle of the strobe is the one committed, as data settles late
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      wr_seen_reg <= 1'b0;
      wr_csr_reg <= 1'b0;
      wr_dp_reg <= 1'b0;
      wr_ofs_reg <= `IHBLS_OFS_RST;
      wr_byte_reg <= `IHBLS_BYTE_RST;
      wr_word_reg <= `IHBLS_WORD_RST;
      csr_wr_stb_reg <= 1'b0;
      dp_wr_stb_reg <= 1'b0;
    end
    else
    begin
      wr_seen_reg <= wr_active;
      csr_wr_stb_reg <= wr_seen_reg && !wr_active && wr_csr_reg; // RULE6 RULE12
      dp_wr_stb_reg <= wr_seen_reg && !wr_active && wr_dp_reg; // RULE9
      if (wr_active)
      begin
        wr_csr_reg <= hit_csr; // RULE10
        wr_dp_reg <= hit_dp && !in_window; // RULE9
        wr_ofs_reg <= ofs;
        wr_byte_reg <= wr_byte;
        wr_word_reg <= HOST_DATA_LANES_I;
      end
    end
  end

  assign CSR_WR_STB_O = csr_wr_stb_reg;
  assign CSR_WR_OFS_O = wr_ofs_reg;
  assign CSR_WR_DATA_O = wr_byte_reg;
  assign DP_WR_STB_O = dp_wr_stb_reg;
  assign DP_WR_DATA_O = wr_word_reg;
  assign BUS_MODE_O = mode_reg;

endmodule

// File: verilog/ihbls_defs.svh
/*
  Constants of the host byte lane steering block: special host addresses,
  lane widths and reset values.
  Assumes it is included by its bare name by every file that needs it.
*/
`ifndef IHBLS_DEFS_SVH
`define IHBLS_DEFS_SVH

// ====================================================
// Host address map
`define IHBLS_ADDR_W 6
`define IHBLS_OFS_W 5
`define IHBLS_ADDR_DP 6'h10
`define IHBLS_ADDR_HOLE 6'h11
`define IHBLS_ADDR_HALF 6'h1E
`define IHBLS_ADDR_SRST 6'h1F
`define IHBLS_ADDR_WIN_BIT 5

// ====================================================
// Lanes and reset values
`define IHBLS_LANE_W 8
`define IHBLS_WORD_W 16
`define IHBLS_BYTE_RST 8'h00
`define IHBLS_WORD_RST 16'h0000
`define IHBLS_OFS_RST 5'h00

`endif

// File: verilog/ihbls_pkg.sv
/*
  Types of the host byte lane steering block.
  Assumes nothing of its surroundings.
*/
package ihbls_pkg;

  // ====================================================
  // Bus personalities chosen by the straps
  typedef enum logic [1:0] {
    IHBLS_MODE_ISA,
    IHBLS_MODE_186,
    IHBLS_MODE_8BIT
  } ihbls_mode_t;

endpackage

// File: bench/ihbls_core_model.sv
/* Core side model: register bytes and packet port head word.
   Assumes offsets come from the steering block. */
module ihbls_core_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] ofs_lo_i,
  input wire logic [4:0] ofs_hi_i,
  input wire logic dp_adv_i,
  output logic [7:0] lo_o,
  output logic [7:0] hi_o,
  output logic [15:0] dp_o
);
  // ==========
  // Byte tells its offset, so a wrong lane shows
  assign lo_o = {3'h5, ofs_lo_i};
  assign hi_o = {3'h5, ofs_hi_i};
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      dp_o <= 16'hD000;
    else if (dp_adv_i)
      dp_o <= dp_o + 16'h0001;
endmodule

// File: bench/ihbls_monitor.sv
/* Checker of the host lane steering ports.
   Assumes a bind to ihbls_steer, one clock. */
module ihbls_monitor
  import ihbls_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic [5:0] ADDR_I,
  input wire logic ADDRESS_ENABLE_INPUT_I,
  input wire logic READ_STROBE_LOW_N_I,
  input wire logic WRITE_STROBE_LOW_N_I,
  input wire logic [1:0] HOST_DATA_LANES_OE_N_O,
  input wire logic [4:0] CSR_RD_OFS_LO_O,
  input wire logic [4:0] CSR_RD_OFS_HI_O,
  input wire logic CSR_WR_STB_O,
  input wire logic DP_RD_STB_O,
  input wire logic SOFT_RESET_O,
  input wire ihbls_mode_t BUS_MODE_O
);
  // ==========
  // Decode seen from the pins
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire isa = BUS_MODE_O == IHBLS_MODE_ISA;
  wire rd = !READ_STROBE_LOW_N_I && (!isa || !ADDRESS_ENABLE_INPUT_I);
  wire wr = !WRITE_STROBE_LOW_N_I && (!isa || !ADDRESS_ENABLE_INPUT_I);
  wire control_status_space = !ADDR_I[5] && ADDR_I[4:1] != 4'h8;
  // Write commits only once the strobe is back high
  sequence s_wr(c);
    wr && c ##1 WRITE_STROBE_LOW_N_I;
  endsequence
  AST_OE: assert property (rd |-> HOST_DATA_LANES_OE_N_O == 2'b00)
    else $error("lanes idle in read");
  AST_OFS_ISA: assert property (rd && isa && control_status_space |-> CSR_RD_OFS_LO_O == ADDR_I[4:0])
    else $error("low lane offset wrong");
  AST_OFS_186: assert property (rd && BUS_MODE_O == IHBLS_MODE_186 |->
    CSR_RD_OFS_LO_O == {ADDR_I[4:1], 1'b0} && CSR_RD_OFS_HI_O == {ADDR_I[4:1], 1'b1})
    else $error("pair offsets wrong");
  AST_WR: assert property (s_wr(control_status_space) |-> ##[1:2] CSR_WR_STB_O)
    else $error("write lost");
  AST_HOLE: assert property (s_wr(ADDR_I == 6'h11) |-> ##1 !CSR_WR_STB_O [*2])
    else $error("hole written");
  AST_SRST: assert property ($fell(READ_STROBE_LOW_N_I) && rd && ADDR_I == 6'h1F |->
    ##[1:2] SOFT_RESET_O)
    else $error("no soft reset");
  AST_DPRD: assert property (rd && ADDR_I == 6'h10 ##1 READ_STROBE_LOW_N_I |->
    ##[1:2] DP_RD_STB_O)
    else $error("port not advanced");
  AST_MODE: assert property ($past(RST_N_I, 2) |-> $stable(BUS_MODE_O))
    else $error("mode moved");
endmodule
bind ihbls_steer ihbls_monitor mon_u (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
  .ADDR_I(ADDR_I), .ADDRESS_ENABLE_INPUT_I(ADDRESS_ENABLE_INPUT_I),
  .READ_STROBE_LOW_N_I(READ_STROBE_LOW_N_I), .WRITE_STROBE_LOW_N_I(WRITE_STROBE_LOW_N_I),
  .HOST_DATA_LANES_OE_N_O(HOST_DATA_LANES_OE_N_O), .CSR_RD_OFS_LO_O(CSR_RD_OFS_LO_O),
  .CSR_RD_OFS_HI_O(CSR_RD_OFS_HI_O), .CSR_WR_STB_O(CSR_WR_STB_O),
  .DP_RD_STB_O(DP_RD_STB_O), .SOFT_RESET_O(SOFT_RESET_O), .BUS_MODE_O(BUS_MODE_O));

// File: bench/ihbls_steer_test.sv
/* Bench of the lane steering block with a core model.
   Assumes inputs move at the falling clock edge. */
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: %h vs %h", $time, (a), (b)); end end
module ihbls_steer_test import ihbls_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic CORE_CLK_I = 0, RST_N_I = 0, EEPROM_SELECT_STRAP_I = 0, EEPROM_CLOCK_STRAP_I = 0;
  logic ADDRESS_ENABLE_INPUT_I = 0, READ_STROBE_LOW_N_I = 1, WRITE_STROBE_LOW_N_I = 1;
  logic [5:0] ADDR_I = 6'h00;
  logic [15:0] HOST_DATA_LANES_I = 16'h0000, HOST_DATA_LANES_O, DP_RD_DATA_I, DP_WR_DATA_O, d;
  logic [1:0] HOST_DATA_LANES_OE_N_O, oe, g;
  logic [4:0] CSR_RD_OFS_LO_O, CSR_RD_OFS_HI_O, CSR_WR_OFS_O;
  logic [7:0] CSR_RD_DATA_LO_I, CSR_RD_DATA_HI_I, CSR_WR_DATA_O;
  logic CSR_WR_STB_O, DP_RD_STB_O, DP_WR_STB_O, SOFT_RESET_O;
  ihbls_mode_t BUS_MODE_O;
  int errors = 0, n_compared = 0, n_srst = 0, n_dprd = 0;
  always #20 CORE_CLK_I = ~CORE_CLK_I;
  // Pulses counted away from the edge that launches them
  always @(negedge CORE_CLK_I)
  begin
    if (SOFT_RESET_O === 1'b1)
      n_srst++;
    if (DP_RD_STB_O === 1'b1)
      n_dprd++;
  end
  ihbls_steer dut_u (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
    .EEPROM_SELECT_STRAP_I(EEPROM_SELECT_STRAP_I),
    .EEPROM_CLOCK_STRAP_I(EEPROM_CLOCK_STRAP_I),
    .ADDR_I(ADDR_I), .ADDRESS_ENABLE_INPUT_I(ADDRESS_ENABLE_INPUT_I),
    .READ_STROBE_LOW_N_I(READ_STROBE_LOW_N_I), .WRITE_STROBE_LOW_N_I(WRITE_STROBE_LOW_N_I),
    .HOST_DATA_LANES_I(HOST_DATA_LANES_I), .HOST_DATA_LANES_O(HOST_DATA_LANES_O),
    .HOST_DATA_LANES_OE_N_O(HOST_DATA_LANES_OE_N_O), .CSR_RD_OFS_LO_O(CSR_RD_OFS_LO_O),
    .CSR_RD_OFS_HI_O(CSR_RD_OFS_HI_O), .CSR_RD_DATA_LO_I(CSR_RD_DATA_LO_I),
    .CSR_RD_DATA_HI_I(CSR_RD_DATA_HI_I), .CSR_WR_STB_O(CSR_WR_STB_O),
    .CSR_WR_OFS_O(CSR_WR_OFS_O), .CSR_WR_DATA_O(CSR_WR_DATA_O),
    .DP_RD_DATA_I(DP_RD_DATA_I), .DP_RD_STB_O(DP_RD_STB_O), .DP_WR_STB_O(DP_WR_STB_O),
    .DP_WR_DATA_O(DP_WR_DATA_O), .SOFT_RESET_O(SOFT_RESET_O), .BUS_MODE_O(BUS_MODE_O));
  ihbls_core_model core_u (.clk_i(CORE_CLK_I), .rst_n_i(RST_N_I), .ofs_lo_i(CSR_RD_OFS_LO_O),
    .ofs_hi_i(CSR_RD_OFS_HI_O), .dp_adv_i(DP_RD_STB_O), .lo_o(CSR_RD_DATA_LO_I),
    .hi_o(CSR_RD_DATA_HI_I), .dp_o(DP_RD_DATA_I));
  function automatic logic [7:0] m(input logic [4:0] o);
    return {3'h5, o};
  endfunction
  // ==========
  // Host cycles
  task automatic rst(input logic s, input logic c);
    @(negedge CORE_CLK_I);
    RST_N_I = 0;
    EEPROM_SELECT_STRAP_I = s;
    EEPROM_CLOCK_STRAP_I = c;
    repeat (5) @(negedge CORE_CLK_I);
    RST_N_I = 1;
    n_srst = 0;
    n_dprd = 0;
    repeat (2) @(negedge CORE_CLK_I);
  endtask
  task automatic rd(input logic [5:0] a);
    @(negedge CORE_CLK_I);
    ADDR_I = a;
    READ_STROBE_LOW_N_I = 0;
    repeat (2) @(negedge CORE_CLK_I);
    d = HOST_DATA_LANES_O;
    oe = HOST_DATA_LANES_OE_N_O;
    READ_STROBE_LOW_N_I = 1;
    repeat (3) @(negedge CORE_CLK_I);
  endtask
  // Pulse lands on the first rising edge after the strobe rises
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(negedge CORE_CLK_I);
    ADDR_I = a;
    HOST_DATA_LANES_I = v;
    WRITE_STROBE_LOW_N_I = 0;
    g = 2'h0;
    @(negedge CORE_CLK_I);
    WRITE_STROBE_LOW_N_I = 1;
    // Strobes kept apart, so a pulse on the wrong port shows
    repeat (3) @(negedge CORE_CLK_I) g |= {CSR_WR_STB_O, DP_WR_STB_O};
  endtask
  // ==========
  // Scenarios
  task automatic t_isa;
    rst(0, 0);
    `CHK(BUS_MODE_O, IHBLS_MODE_ISA)
    rd(6'h04);
    `CHK({oe, d}, {2'b00, m(5'h05), m(5'h04)})
    rd(6'h05);
    `CHK(d, {m(5'h05), m(5'h05)})
    wr(6'h06, 16'hA5C3);
    `CHK({g, CSR_WR_OFS_O, CSR_WR_DATA_O}, {2'h2, 5'h06, 8'hC3})
    ADDRESS_ENABLE_INPUT_I = 1;
    rd(6'h04);
    `CHK(oe, 2'b11)
    wr(6'h07, 16'h0011);
    `CHK(g, 2'h0)
    ADDRESS_ENABLE_INPUT_I = 0;
    rd(6'h10);
    `CHK({d, 1'b1}, {16'hD000, n_dprd == 1})
    wr(6'h10, 16'hBEEF);
    `CHK({g, DP_WR_DATA_O}, {2'h1, 16'hBEEF})
    rd(6'h1E);
    `CHK(d, {8'h00, m(5'h1E)})
    rd(6'h11);
    wr(6'h11, 16'h1234);
    `CHK({g, d}, 18'h00000)
    rd(6'h1F);
    `CHK(n_srst, 1)
    $display("t_isa done");
  endtask
  task automatic t_186;
    rst(0, 1);
    `CHK(BUS_MODE_O, IHBLS_MODE_186)
    ADDRESS_ENABLE_INPUT_I = 1;
    rd(6'h05);
    `CHK(d, {m(5'h05), m(5'h04)})
    wr(6'h07, 16'h3CA5);
    `CHK({g, CSR_WR_OFS_O, CSR_WR_DATA_O}, {2'h2, 5'h07, 8'h3C})
    wr(6'h04, 16'h3CA5);
    `CHK({g, CSR_WR_OFS_O, CSR_WR_DATA_O}, {2'h2, 5'h04, 8'hA5})
    wr(6'h1F, 16'h9655);
    `CHK({g, CSR_WR_OFS_O, CSR_WR_DATA_O}, {2'h2, 5'h1F, 8'h96})
    `CHK(n_srst, 0)
    EEPROM_SELECT_STRAP_I = 1;
    rd(6'h02);
    `CHK(BUS_MODE_O, IHBLS_MODE_186)
    ADDRESS_ENABLE_INPUT_I = 0;
    rst(1, 1);
    `CHK(BUS_MODE_O, IHBLS_MODE_8BIT)
    $display("t_186 done");
  endtask
  task automatic end_sim;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    t_isa;
    t_186;
    end_sim;
  end
endmodule
